/* File: rtl/rftx_pkg.sv */
// shared constants for the rf transmit frame timing and status registers
package rftx_pkg;

  // ==========================================================
  // register map
  localparam int         DATA_W          = 8;
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] TX_CTRL_ADDR    = 8'h32;
  localparam logic [7:0] FRAME_CFG_ADDR  = 8'h33;
  localparam logic [7:0] BASE_TIME_ADDR  = 8'h34;
  localparam logic [7:0] RAND_SEED_ADDR  = 8'h35;
  localparam logic [7:0] FRAME_TIME_ADDR = 8'h36;
  localparam logic [7:0] STATUS_ADDR     = 8'h37;

  // ==========================================================
  // field positions
  localparam int SEND_BIT      = 7;
  localparam int EXTRA_GAP_BIT = 4;
  localparam int FCOUNT_W      = 4;
  localparam int BOOST_BIT     = 7;
  localparam int SEED_W        = 7;
  localparam int FT_W          = 6;
  localparam int GAIN_LSB      = 6;
  localparam int DONE_BIT      = 7;
  localparam int ERR_BIT       = 6;
  localparam int DROP_BIT      = 5;
  localparam int ACK_BIT       = 4;
  localparam int IEN_BIT       = 3;
  localparam int MON_BIT       = 2;
  localparam int CTS_BIT       = 1;
  localparam int SRST_BIT      = 0;
  localparam int FNUM_W        = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0]        BASE_RST  = 8'h00;
  localparam logic [SEED_W-1:0] SEED_RST  = 7'h00;
  localparam logic [FT_W-1:0]   FT_RST    = 6'h00;
  localparam logic [1:0]        GAIN_RST  = 2'h2;
  localparam logic [7:0]        RDATA_RST = 8'h00;

  // ==========================================================
  // timing
  localparam int TICK_NS     = 1000000;
  localparam int CLK_NS      = 40;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int IVL_W       = 12;

  // x^7 + x^6 + 1, maximal length
  localparam logic [SEED_W-1:0] LFSR_TAPS = 7'h60;

  // total gap in ms ticks: base + random + frame time * frame number
  function automatic logic [IVL_W-1:0] gap_ms(
    input logic [7:0]        base,
    input logic [SEED_W-1:0] rnd,
    input logic [FT_W-1:0]   ft,
    input logic [FNUM_W-1:0] fnum
  );
    logic [IVL_W-1:0] prod;
    prod = IVL_W'(ft) * IVL_W'(fnum);
    gap_ms = IVL_W'(base) + IVL_W'(rnd) + prod;
  endfunction : gap_ms

endpackage : rftx_pkg

/* File: rtl/rftx_lfsr.sv */
// seven bit pseudo-random interval generator
`timescale 1ns/10ps
module rftx_lfsr (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        arst_n_in,
  // control
  input  wire logic                        clear_in,
  input  wire logic                        load_in,
  input  wire logic [rftx_pkg::SEED_W-1:0] seed_in,
  input  wire logic                        step_in,
  // state
  output logic      [rftx_pkg::SEED_W-1:0] value_out
);

  // ==========================================================
  // shift register
  // an all-zero state feeds back zero, so stepping never leaves zero; only a load does
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      value_out <= rftx_pkg::SEED_RST;
    end else if (clear_in) begin
      value_out <= rftx_pkg::SEED_RST;
    end else if (load_in) begin
      value_out <= seed_in;
    end else if (step_in) begin
      value_out <= {value_out[rftx_pkg::SEED_W-2:0],
                    ^(value_out & rftx_pkg::LFSR_TAPS)};
    end
  end

endmodule : rftx_lfsr

/* File: rtl/rftx_gap_timer.sv */
// millisecond tick prescaler and interframe gap counter
`timescale 1ns/10ps
module rftx_gap_timer #(
  parameter int TICK_CYCLES = rftx_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       arst_n_in,
  // control
  input  wire logic                       abort_in,
  input  wire logic                       start_in,
  input  wire logic [rftx_pkg::IVL_W-1:0] interval_in,
  // result
  output logic                            done_out
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  logic [PW-1:0]             pre_r;
  logic [rftx_pkg::IVL_W-1:0] ms_r;
  logic                      busy_r;

  // ==========================================================
  // counter
  // prescaler restarts with each gap so every tick is a full 1 ms
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_r <= 1'b0;
      pre_r  <= '0;
      ms_r   <= '0;
    end else if (abort_in || start_in) begin
      busy_r <= start_in && !abort_in;
      pre_r  <= '0;
      ms_r   <= interval_in;
    end else if (busy_r) begin
      if (ms_r == '0) begin
        busy_r <= 1'b0;
      end else if (pre_r == PW'(TICK_CYCLES - 1)) begin
        pre_r <= '0;
        ms_r  <= ms_r - 12'h001;
      end else begin
        pre_r <= pre_r + PW'(1);
      end
    end
  end

  assign done_out = busy_r && (ms_r == '0);

endmodule : rftx_gap_timer

/* File: rtl/rftx_regs.sv */
// rf transmit frame timing, boost, gain and status register bank
//
// Behaviour
// - base gap is base_interval_count times a 1 ms tick
// - module soft reset clears the whole base time field
// - seed is copied into the working lfsr when start is set
// - random gap is lfsr value times 1 ms, only if seed nonzero
// - an all-zero lfsr stays zero on every step
// - module soft reset clears the seed field
// - boost bit picks vco power level; cleared by module reset
// - frame gap is frame time times 1 ms times last frame number
// - module reset sets upper gain bit and clears lower gain bit
// - done flag sets when transmission ends and start clears; read only
// - error flag records a transmission error; read only
// - supply drop flag sets when monitored supply falls; sticky
// - writing 1 to acknowledge clears done, error and drop flags
// - irq asserts when enabled and done or error is set
// - monitor enable bit switches the supply monitor; reset clears
// - clear to send reads 1 only once the synthesiser is locked
// - writing 1 to reset bit resets module registers; reads 0
// - start bit clears at end or on reset; writing 0 aborts
// - frames per datagram is frame_count plus one
// - option delays done until one more gap after last frame
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module rftx_regs #(
  parameter int TICK_CYCLES = rftx_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        arst_n_in,
  // register port
  input  wire logic [rftx_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [rftx_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [rftx_pkg::DATA_W-1:0] rdata_out,
  // frame engine
  input  wire logic                        frame_done_in,
  input  wire logic                        tx_error_in,
  output logic                             frame_start_out,
  output logic                             send_out,
  // analog status and controls
  input  wire logic                        supply_low_in,
  input  wire logic                        pll_locked_in,
  output logic                             supply_monitor_enable_out,
  output logic                             vco_boost_out,
  output logic      [1:0]                  osc_gain_out,
  output logic                             module_reset_out,
  // processor interrupt
  output logic                             irq_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP} rftx_state_t;

  rftx_state_t                       state_r;
  logic [7:0]                        base_r;
  logic [rftx_pkg::SEED_W-1:0]       seed_r;
  logic                              boost_r;
  logic [rftx_pkg::FT_W-1:0]         ft_r;
  logic [rftx_pkg::FCOUNT_W-1:0]     fcount_r;
  logic                              extra_gap_r;
  logic                              irq_en_r;
  logic                              mon_en_r;
  logic                              send_r;
  logic                              done_r;
  logic                              err_r;
  logic                              drop_r;
  logic                              cts_r;
  logic [rftx_pkg::FCOUNT_W-1:0]     left_r;
  logic [rftx_pkg::FNUM_W-1:0]       fnum_r;
  logic                              last_r;
  logic [rftx_pkg::SEED_W-1:0]       lfsr_val;
  logic [rftx_pkg::FNUM_W-1:0]       fnum_nxt;
  logic [rftx_pkg::SEED_W-1:0]       rnd_part;
  logic [rftx_pkg::IVL_W-1:0]        ivl_nxt;
  logic                              wr_ctrl;
  logic                              wr_stat;
  logic                              srst;
  logic                              ack;
  logic                              start_evt;
  logic                              abort_evt;
  logic                              gap_done;
  logic                              frame_end;
  logic                              finish;
  logic                              gap_start;
  logic                              next_frame;
  logic                              drop_evt;

  // ==========================================================
  // write decode
  assign wr_ctrl = wr_in && (addr_in == rftx_pkg::TX_CTRL_ADDR);
  assign wr_stat = wr_in && (addr_in == rftx_pkg::STATUS_ADDR);
  assign srst    = wr_stat && wdata_in[rftx_pkg::SRST_BIT];
  assign ack     = wr_stat && wdata_in[rftx_pkg::ACK_BIT];
  assign start_evt = wr_ctrl && wdata_in[rftx_pkg::SEND_BIT] && !send_r;
  assign abort_evt = wr_ctrl && !wdata_in[rftx_pkg::SEND_BIT] && send_r;
  assign drop_evt  = mon_en_r && supply_low_in;

  // ==========================================================
  // sequencing terms
  assign frame_end  = (state_r == ST_FRAME) && frame_done_in;
  assign finish     = (frame_end && (left_r == '0) && !extra_gap_r) ||
                      ((state_r == ST_GAP) && gap_done && last_r);
  assign gap_start  = frame_end && !finish;
  assign next_frame = (state_r == ST_GAP) && gap_done && !last_r;
  assign fnum_nxt   = fnum_r + 5'h01;
  assign rnd_part   = (seed_r != '0) ? lfsr_val : '0;
  assign ivl_nxt    = rftx_pkg::gap_ms(base_r, rnd_part, ft_r,
                                       fnum_nxt);

  // ==========================================================
  // configuration registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      base_r       <= rftx_pkg::BASE_RST;
      seed_r       <= rftx_pkg::SEED_RST;
      boost_r      <= 1'b0;
      ft_r         <= rftx_pkg::FT_RST;
      osc_gain_out <= rftx_pkg::GAIN_RST;
      fcount_r     <= '0;
      extra_gap_r  <= 1'b0;
      irq_en_r     <= 1'b0;
      mon_en_r     <= 1'b0;
    end else if (srst) begin
      base_r       <= rftx_pkg::BASE_RST;
      seed_r       <= rftx_pkg::SEED_RST;
      boost_r      <= 1'b0;
      ft_r         <= rftx_pkg::FT_RST;
      osc_gain_out <= rftx_pkg::GAIN_RST;
      fcount_r     <= '0;
      extra_gap_r  <= 1'b0;
      irq_en_r     <= 1'b0;
      mon_en_r     <= 1'b0;
    end else if (wr_in) begin
      unique case (addr_in)
        rftx_pkg::FRAME_CFG_ADDR: begin
          extra_gap_r <= wdata_in[rftx_pkg::EXTRA_GAP_BIT];
          fcount_r    <= wdata_in[rftx_pkg::FCOUNT_W-1:0];
        end
        rftx_pkg::BASE_TIME_ADDR: begin
          base_r <= wdata_in;
        end
        rftx_pkg::RAND_SEED_ADDR: begin
          boost_r <= wdata_in[rftx_pkg::BOOST_BIT];
          seed_r  <= wdata_in[rftx_pkg::SEED_W-1:0];
        end
        rftx_pkg::FRAME_TIME_ADDR: begin
          osc_gain_out <= wdata_in[rftx_pkg::GAIN_LSB+:2];
          ft_r         <= wdata_in[rftx_pkg::FT_W-1:0];
        end
        rftx_pkg::STATUS_ADDR: begin
          irq_en_r <= wdata_in[rftx_pkg::IEN_BIT];
          mon_en_r <= wdata_in[rftx_pkg::MON_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // start bit and frame sequencer
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      send_r <= 1'b0;
    end else if (srst || abort_evt || finish) begin
      send_r <= 1'b0;
    end else if (start_evt) begin
      send_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
      left_r  <= '0;
      fnum_r  <= '0;
      last_r  <= 1'b0;
    end else if (srst || abort_evt) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_evt) begin
            state_r <= ST_FRAME;
            left_r  <= fcount_r;
            fnum_r  <= '0;
            last_r  <= 1'b0;
          end
        end
        ST_FRAME: begin
          if (frame_end) begin
            fnum_r <= fnum_nxt;
            if (finish) begin
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_GAP;
              last_r  <= (left_r == '0);
            end
            if (left_r != '0) begin
              left_r <= left_r - 4'h1;
            end
          end
        end
        ST_GAP: begin
          if (gap_done) begin
            state_r <= last_r ? ST_IDLE : ST_FRAME;
          end
        end
      endcase
    end
  end

  // frame start pulse is registered so the frame engine sees clean data
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame_start_out <= 1'b0;
    end else begin
      frame_start_out <= (start_evt || next_frame) && !srst;
    end
  end

  // ==========================================================
  // timing sub-blocks
  rftx_lfsr u_lfsr (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .clear_in    (srst),
    .load_in     (start_evt),
    .seed_in     (seed_r),
    .step_in     (gap_start),
    .value_out   (lfsr_val)
  );

  rftx_gap_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_gap (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .abort_in    (srst || abort_evt),
    .start_in    (gap_start),
    .interval_in (ivl_nxt),
    .done_out    (gap_done)
  );

  // ==========================================================
  // status flags
  // a set in the same cycle as acknowledge wins, so no event is lost
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
      drop_r <= 1'b0;
      cts_r  <= 1'b0;
    end else begin
      done_r <= finish || (done_r && !ack && !srst);
      err_r  <= tx_error_in || (err_r && !ack && !srst);
      drop_r <= drop_evt || (drop_r && !ack && !srst);
      cts_r  <= pll_locked_in && !srst;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      module_reset_out <= 1'b0;
    end else begin
      module_reset_out <= srst;
    end
  end

  // ==========================================================
  // read port
  // ack and reset bits are strobes and always read back as zero
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= rftx_pkg::RDATA_RST;
    end else if (rd_in) begin
      unique case (addr_in)
        rftx_pkg::TX_CTRL_ADDR:    rdata_out <= {send_r, 7'h00};
        rftx_pkg::FRAME_CFG_ADDR:  rdata_out <= {3'h0, extra_gap_r, fcount_r};
        rftx_pkg::BASE_TIME_ADDR:  rdata_out <= base_r;
        rftx_pkg::RAND_SEED_ADDR:  rdata_out <= {boost_r, seed_r};
        rftx_pkg::FRAME_TIME_ADDR: rdata_out <= {osc_gain_out, ft_r};
        rftx_pkg::STATUS_ADDR:     rdata_out <= {done_r, err_r, drop_r,
                                   1'b0, irq_en_r, mon_en_r, cts_r, 1'b0};
        default:                   rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  assign send_out                  = send_r;
  assign vco_boost_out             = boost_r;
  assign supply_monitor_enable_out = mon_en_r;
  assign irq_out = irq_en_r && (done_r || err_r);

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  base_soft_clear_a: assert property (srst |=> base_r == 8'h00)
    else $error("base time not cleared by soft reset");
  seed_soft_clear_a: assert property (srst |=> seed_r == 7'h00)
    else $error("seed not cleared by soft reset");
  boost_soft_clear_a: assert property (srst |=> !vco_boost_out)
    else $error("boost not cleared by soft reset");
  gain_reset_a: assert property (srst |=> osc_gain_out == 2'h2)
    else $error("gain select wrong after soft reset");
  seed_load_a: assert property (start_evt |=>
      lfsr_val == $past(seed_r))
    else $error("seed not loaded at start");
  lfsr_zero_a: assert property ((lfsr_val == 7'h00 && !start_evt)
      |=> lfsr_val == 7'h00)
    else $error("zero lfsr left zero state");
  done_end_a: assert property ($rose(done_r) |-> !send_r)
    else $error("done set while start still set");
  err_set_a: assert property (tx_error_in |=> err_r ##1
      (err_r || $past(ack || srst)))
    else $error("error flag not held");
  drop_set_a: assert property (drop_evt |=> drop_r)
    else $error("supply drop flag not set");
  ack_clear_a: assert property ((ack && !finish && !tx_error_in
      && !drop_evt) |=> !(done_r || err_r || drop_r))
    else $error("flags not cleared by acknowledge");
  irq_flag_a: assert property (($rose(done_r) && irq_en_r)
      |-> irq_out)
    else $error("irq missing for done flag");
  cts_lock_a: assert property (!pll_locked_in |=> !cts_r)
    else $error("clear to send without lock");
  send_end_a: assert property (finish |=> !send_out ##0 done_r)
    else $error("start bit not cleared at end");
  extra_gap_a: assert property ((frame_end && left_r == '0
      && extra_gap_r && !abort_evt && !srst) |=> send_r && state_r == ST_GAP)
    else $error("extra gap not taken after last frame");
  mon_write_a: assert property ((wr_stat && !srst) |=>
      mon_en_r == $past(wdata_in[rftx_pkg::MON_BIT]))
    else $error("monitor enable not written");

  single_frame_c: cover property (start_evt ##[1:300] finish);
  multi_gap_c: cover property (gap_start ##[1:1000] next_frame);
  abort_c: cover property (send_r ##1 abort_evt);
  ack_race_c: cover property (ack && finish);

endmodule : rftx_regs

/* File: bench/rftx_engine_model.sv */
// behavioural frame engine that answers the register bank's frame starts
`timescale 1ns/10ps
module rftx_engine_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // frame handshake
  input  wire logic        frame_start_in,
  output logic             frame_done_out,
  // observation
  output logic [7:0]       starts_out,
  output logic [15:0]      gap_out
);
  logic [7:0]  cnt_r;
  logic        busy_r;
  logic [15:0] gcnt_r;

  // ==========================================================
  // frame sender
  // gap_out holds edges from the last frame done to the next start
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r          <= 8'h00;
      busy_r         <= 1'b0;
      frame_done_out <= 1'b0;
      starts_out     <= 8'h00;
      gap_out        <= 16'h0000;
      gcnt_r         <= 16'h0000;
    end else begin
      frame_done_out <= 1'b0;
      gcnt_r         <= gcnt_r + 16'h0001;
      if (frame_start_in) begin
        starts_out <= starts_out + 8'h01;
        busy_r     <= 1'b1;
        cnt_r      <= 8'h00;
        gap_out    <= gcnt_r;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == 8'(DLY - 1)) begin
          frame_done_out <= 1'b1;
          busy_r         <= 1'b0;
          gcnt_r         <= 16'h0000;
        end
      end
    end
  end
endmodule : rftx_engine_model

/* File: bench/rftx_regs_tb.sv */
// self-checking bench for the rf transmit timing and status registers
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module rftx_regs_tb;
  // short tick keeps gaps to a few dozen cycles
  localparam int T = 8;
  logic        core_clk_in = 1'b0;
  logic        arst_n_in   = 1'b0;
  logic [7:0]  addr        = 8'h00;
  logic [7:0]  wdata       = 8'h00;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic        ferr        = 1'b0;
  logic        slow        = 1'b0;
  logic        lock        = 1'b0;
  logic [7:0]  rdata;
  logic        fdone;
  logic        fstart;
  logic        send;
  logic        mon;
  logic        boost;
  logic        mrst;
  logic        irq;
  logic [1:0]  gain;
  logic [7:0]  starts;
  logic [15:0] gap;
  logic [31:0] rnd_r       = 32'hB2BC;
  int          n_mismatch  = 0;
  int          tests_run   = 0;

  always #20 core_clk_in = ~core_clk_in;

  rftx_regs #(.TICK_CYCLES(T)) rftx_regs_i (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .frame_done_in(fdone), .tx_error_in(ferr), .frame_start_out(fstart),
    .send_out(send), .supply_low_in(slow), .pll_locked_in(lock),
    .supply_monitor_enable_out(mon), .vco_boost_out(boost),
    .osc_gain_out(gain), .module_reset_out(mrst), .irq_out(irq));

  rftx_engine_model rftx_engine_model_i (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .frame_start_in(fstart), .frame_done_out(fdone),
    .starts_out(starts), .gap_out(gap));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = x[0] ? ((x >> 1) ^ 32'hB4BCD35C) : (x >> 1);
  endfunction : lfsr_next

  function automatic int exp_gap(input int b, input int s, input int f,
                                 input int n);
    exp_gap = b + s + f * n;
  endfunction : exp_gap

  // random part of a gap: seed stepped once per earlier gap, x^7+x^6+1
  function automatic int exp_rnd(input logic [6:0] sd, input int n);
    logic [6:0] v;
    v = sd;
    for (int j = 0; j < n; j++) begin
      v = {v[5:0], v[6] ^ v[5]};
    end
    exp_rnd = int'(v);
  endfunction : exp_rnd

  task automatic get_rnd(output logic [7:0] v);
    rnd_r = lfsr_next(rnd_r);
    v = rnd_r[7:0];
  endtask : get_rnd

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk_in);
    rd <= 1'b0;
    @(negedge core_clk_in);
    `CHK("rdata", e, rdata)
  endtask : rd_chk

  task automatic wait_idle();
    int k;
    k = 0;
    @(negedge core_clk_in);
    while (send === 1'b1 && k < 8000) begin
      @(negedge core_clk_in);
      k++;
    end
    if (send !== 1'b0) begin
      n_mismatch++;
    end
  endtask : wait_idle

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(40 * 40000);
    n_mismatch++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] r;
    logic [7:0] b;
    logic [7:0] n0;
    logic [6:0] s;
    logic [5:0] f;
    logic [3:0] fc;
    int         g;
    repeat (10) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h36, 8'h80);
    rd_chk(8'h37, 8'h00);
    rd_chk(8'h40, 8'h00);
    `CHK("gain", 2'h2, gain)
    // a supply drop while the monitor is off must leave no trace
    slow <= 1'b1;
    rd_chk(8'h37, 8'h00);
    wr_reg(8'h37, 8'h04);
    rd_chk(8'h37, 8'h24);
    slow <= 1'b0;
    lock <= 1'b1;
    rd_chk(8'h37, 8'h26);
    `CHK("mon", 1'b1, mon)
    wr_reg(8'h37, 8'hFC);
    rd_chk(8'h37, 8'h0E);
    @(posedge core_clk_in);
    ferr <= 1'b1;
    @(posedge core_clk_in);
    ferr <= 1'b0;
    @(negedge core_clk_in);
    `CHK("irq", 1'b1, irq)
    rd_chk(8'h37, 8'h4E);
    wr_reg(8'h37, 8'h14);
    rd_chk(8'h37, 8'h06);
    `CHK("irq", 1'b0, irq)
    wr_reg(8'h37, 8'h0C);
    for (int i = 0; i < 5; i++) begin
      get_rnd(r);
      b  = {6'h00, r[1:0]};
      s  = (i == 3) ? 7'h00 : 7'({4'h0, r[4:2]} + 7'h01);
      f  = {4'h0, r[7:6]};
      fc = 4'(i % 4);
      wr_reg(8'h34, b);
      wr_reg(8'h35, {r[5], s});
      wr_reg(8'h36, {2'h2, f});
      wr_reg(8'h33, {3'h0, (i == 4), fc});
      n0 = starts;
      wr_reg(8'h32, 8'h80);
      wait_idle();
      `CHK("frames", 8'(n0 + fc + 8'h01), starts)
      `CHK("boost", r[5], boost)
      if (fc != 4'h0) begin
        // last gap: ms count times tick, plus done-to-start latency of 2
        g = exp_gap(b, exp_rnd(s, fc - 1), f, fc) * T + 2;
        `CHK("gap", 16'(g), gap)
      end
      `CHK("irq", 1'b1, irq)
      rd_chk(8'h37, 8'h8E);
      wr_reg(8'h37, 8'h1C);
    end
    // abort straight after the start
    wr_reg(8'h33, 8'h00);
    wr_reg(8'h32, 8'h80);
    wr_reg(8'h32, 8'h00);
    repeat (8) @(posedge core_clk_in);
    `CHK("send", 1'b0, send)
    rd_chk(8'h37, 8'h0E);
    wr_reg(8'h34, 8'hFF);
    wr_reg(8'h35, 8'hFF);
    wr_reg(8'h36, 8'h3F);
    wr_reg(8'h37, 8'h01);
    @(negedge core_clk_in);
    `CHK("mrst", 1'b1, mrst)
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h36, 8'h80);
    rd_chk(8'h37, 8'h02);
    `CHK("gain", 2'h2, gain)
    finish_test();
  end
endmodule : rftx_regs_tb
